//--- inc/flag_win_if.sv
`default_nettype none
interface flag_win_if;
    import flag_xfer_pkg::*;
    logic req;
    logic we;
    logic [WIN_AW-1:0] addr;
    logic [BYTE_W-1:0] wdata;
    logic ack;
    logic [BYTE_W-1:0] rdata;
    modport dev (output req, output we, output addr, output wdata, input ack, input rdata);
    modport peer (input req, input we, input addr, input wdata, output ack, output rdata);
endinterface
`default_nettype wire

//--- inc/flag_xfer_pkg.sv
`default_nettype none
package flag_xfer_pkg;
    // ----------------------------------------------------------------
    // Shared window geometry
    // ----------------------------------------------------------------
    localparam int WIN_BYTES = 256;
    localparam int WIN_AW = 8;
    localparam int BYTE_W = 8;
    localparam logic [WIN_AW-1:0] WIN_FIRST = 8'h00;
    localparam logic [WIN_AW-1:0] WIN_LAST = 8'hFF;
    localparam int BLK_COUNT = 8;
    localparam int BLK_SEL_LSB = 5;
    localparam int BLK_SEL_MSB = 7;
    // ----------------------------------------------------------------
    // Restart parameter table layout
    // ----------------------------------------------------------------
    localparam int TBL_W = 16;
    localparam int TBL_AW = 10;
    localparam logic [TBL_AW-1:0] TBL_FIRST = 10'h000;
    localparam logic [TBL_AW-1:0] HDR_IDX1 = 10'h001;
    localparam logic [TBL_AW-1:0] TBL_LAST = 10'h3FF;
    localparam logic [TBL_AW-1:0] HDR_WORDS = 10'h003;
    localparam logic [TBL_W-1:0] HDR_WORD0 = 16'h4D41;
    localparam logic [TBL_W-1:0] HDR_WORD1 = 16'h534B;
    localparam logic [TBL_W-1:0] HDR_WORD2 = 16'h3031;
    localparam logic [TBL_W-1:0] MARK_INPUT = 16'hCE00;
    localparam logic [TBL_W-1:0] MARK_OUTPUT = 16'hCA00;
    localparam logic [TBL_W-1:0] MARK_END = 16'hEEEE;
    localparam logic [TBL_W-1:0] ENTRY_MAX = 16'h00FF;
    // ----------------------------------------------------------------
    // Inbound buffer
    // ----------------------------------------------------------------
    localparam int FIFO_DEPTH = 8;
    localparam int FIFO_W = WIN_AW + BYTE_W;
    typedef enum logic [1:0] {LIST_NONE, LIST_IN, LIST_OUT} list_e;
endpackage
`default_nettype wire

//--- rtl/flag_window_peer.sv
`default_nettype none
module flag_window_peer
    import flag_xfer_pkg::*;
(
    // Clock, reset, enable
    input wire logic CORE_CLK,
    input wire logic RST,
    input wire logic CE,
    // Block enables, one per 32-byte block (static straps)
    input wire logic [BLK_COUNT-1:0] BLK_EN,
    // Partner-side access to the window
    input wire logic PEER_WE,
    input wire logic [WIN_AW-1:0] PEER_ADDR,
    input wire logic [BYTE_W-1:0] PEER_WDATA,
    output logic [BYTE_W-1:0] PEER_RDATA,
    // Shared window
    flag_win_if.peer WIN
);
    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    logic [BYTE_W-1:0] mem_reg [WIN_BYTES];
    logic [BLK_COUNT-1:0] en_meta_reg;
    logic [BLK_COUNT-1:0] en_reg;
    logic ack_reg;
    logic [BYTE_W-1:0] rdata_reg;
    logic [BYTE_W-1:0] peer_rdata_reg;

    wire take = WIN.req && !ack_reg;
    // Disabled blocks still answer so the engine never hangs; they read zero
    wire hit = en_reg[WIN.addr[BLK_SEL_MSB:BLK_SEL_LSB]];

    always_ff @(posedge CORE_CLK) begin
        if (RST) begin
            en_meta_reg <= '0;
            en_reg <= '0;
        end else if (CE) begin
            en_meta_reg <= BLK_EN;
            en_reg <= en_meta_reg;
        end
    end

    // ----------------------------------------------------------------
    // Window storage
    // ----------------------------------------------------------------
    always_ff @(posedge CORE_CLK) begin
        if (RST) begin
            for (int i = 0; i < WIN_BYTES; i++) begin
                mem_reg[i] <= '0;
            end
            ack_reg <= 1'b0;
            rdata_reg <= '0;
            peer_rdata_reg <= '0;
        end else if (CE) begin
            ack_reg <= take;
            peer_rdata_reg <= mem_reg[PEER_ADDR];
            if (take) begin
                rdata_reg <= hit ? mem_reg[WIN.addr] : '0;
            end
            // Engine write wins a same-cycle collision with the local port
            if (take && WIN.we && hit) begin
                mem_reg[WIN.addr] <= WIN.wdata;
            end else if (PEER_WE) begin
                mem_reg[PEER_ADDR] <= PEER_WDATA;
            end
        end
    end

    assign WIN.ack = ack_reg;
    assign WIN.rdata = rdata_reg;
    assign PEER_RDATA = peer_rdata_reg;
endmodule // flag_window_peer

// ----------------------------------------------------------------
// Inbound buffer used by the engine
// ----------------------------------------------------------------
module flag_xfer_fifo #(
    parameter int W = 16,
    parameter int D = 8
) (
    // Clock and control
    input wire logic clk,
    input wire logic rst,
    input wire logic ce,
    // Fill side
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [W-1:0] in_data,
    // Drain side
    output logic out_valid,
    input wire logic out_ready,
    output logic [W-1:0] out_data
);
    localparam int AW = $clog2(D);
    localparam logic [AW:0] CNT_FULL = (AW+1)'(D);
    localparam logic [AW-1:0] PTR_LAST = AW'(D - 1);

    logic [W-1:0] mem_reg [D];
    logic [AW-1:0] wptr_reg;
    logic [AW-1:0] rptr_reg;
    logic [AW:0] cnt_reg;
    wire push = in_valid && in_ready;
    wire pop = out_valid && out_ready;

    assign in_ready = (cnt_reg != CNT_FULL);
    assign out_valid = (cnt_reg != '0);
    assign out_data = mem_reg[rptr_reg];

    always_ff @(posedge clk) begin
        if (rst) begin
            wptr_reg <= '0;
            rptr_reg <= '0;
            cnt_reg <= '0;
        end else if (ce) begin
            if (push) begin
                mem_reg[wptr_reg] <= in_data;
                wptr_reg <= (wptr_reg == PTR_LAST) ? '0 : wptr_reg + 1'b1;
            end
            if (pop) begin
                rptr_reg <= (rptr_reg == PTR_LAST) ? '0 : rptr_reg + 1'b1;
            end
            if (push && !pop) begin
                cnt_reg <= cnt_reg + 1'b1;
            end else if (pop && !push) begin
                cnt_reg <= cnt_reg - 1'b1;
            end
        end
    end
endmodule // flag_xfer_fifo
`default_nettype wire

//--- rtl/flag_xfer_engine.sv
`default_nettype none
module flag_xfer_engine
    import flag_xfer_pkg::*;
(
    // Clock, reset, enable
    input wire logic CORE_CLK,
    input wire logic RST,
    input wire logic CE,
    // Pass sequencing
    input wire logic RESTART,
    input wire logic PASS_START,
    input wire logic PASS_END,
    output logic IN_DONE,
    output logic OUT_DONE,
    output logic BUSY,
    output logic CFG_VALID,
    // Restart parameter table
    output logic TBL_RD,
    output logic [TBL_AW-1:0] TBL_ADDR,
    input wire logic [TBL_W-1:0] TBL_DATA,
    // Program access to local flag image
    input wire logic FLAG_WE,
    input wire logic [WIN_AW-1:0] FLAG_ADDR,
    input wire logic [BYTE_W-1:0] FLAG_WDATA,
    output logic [BYTE_W-1:0] FLAG_RDATA,
    // Shared window
    flag_win_if.dev WIN
);
    typedef enum logic [3:0] {
        S_IDLE, S_TRD, S_TWAIT, S_TCHK, S_IN_SCAN, S_IN_WAIT, S_IN_DRAIN, S_OUT_SCAN, S_OUT_WAIT
    } state_e;

    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    state_e state_reg;
    list_e list_reg;
    logic [BYTE_W-1:0] img_reg [WIN_BYTES];
    logic [WIN_BYTES-1:0] in_cfg_reg;
    logic [WIN_BYTES-1:0] out_cfg_reg;
    logic [WIN_AW-1:0] idx_reg;
    logic [TBL_AW-1:0] word_reg;
    logic req_reg, we_reg;
    logic [WIN_AW-1:0] addr_reg;
    logic [BYTE_W-1:0] wdata_reg;
    logic tbl_rd_reg;
    logic [TBL_AW-1:0] tbl_addr_reg;
    logic in_done_reg, out_done_reg;
    logic busy_reg;
    logic cfg_valid_reg;
    logic [BYTE_W-1:0] flag_rdata_reg;

    // ----------------------------------------------------------------
    // Decode
    // ----------------------------------------------------------------
    wire fifo_in_ready, fifo_out_valid;
    wire [FIFO_W-1:0] fifo_out_data;
    wire fifo_push = (state_reg == S_IN_WAIT) && WIN.ack;
    // Program writes win the image port; the buffer waits and can fill
    wire fifo_pop = fifo_out_valid && !FLAG_WE;
    wire [WIN_AW-1:0] pop_addr = fifo_out_data[FIFO_W-1:BYTE_W];
    wire [BYTE_W-1:0] pop_data = fifo_out_data[BYTE_W-1:0];
    wire idx_last = (idx_reg == WIN_LAST);
    wire [TBL_W-1:0] hdr_expect = (word_reg == TBL_FIRST) ? HDR_WORD0 : (word_reg == HDR_IDX1) ? HDR_WORD1 : HDR_WORD2;
    wire in_header = (word_reg < HDR_WORDS);
    wire hdr_bad = in_header && (TBL_DATA != hdr_expect);
    wire is_entry = (TBL_DATA <= ENTRY_MAX);
    wire [WIN_AW-1:0] entry_idx = TBL_DATA[WIN_AW-1:0];
    wire parse_stop = hdr_bad || (!in_header && TBL_DATA == MARK_END) || (word_reg == TBL_LAST);

    flag_xfer_fifo #(.W(FIFO_W), .D(FIFO_DEPTH)) i_flag_xfer_fifo (
        .clk(CORE_CLK),
        .rst(RST),
        .ce(CE),
        .in_valid(fifo_push),
        .in_ready(fifo_in_ready),
        .in_data({addr_reg, WIN.rdata}),
        .out_valid(fifo_out_valid),
        .out_ready(!FLAG_WE),
        .out_data(fifo_out_data)
    );

    // ----------------------------------------------------------------
    // Local flag image
    // ----------------------------------------------------------------
    always_ff @(posedge CORE_CLK) begin
        if (RST) begin
            for (int i = 0; i < WIN_BYTES; i++) begin
                img_reg[i] <= '0;
            end
            flag_rdata_reg <= '0;
        end else if (CE) begin
            flag_rdata_reg <= img_reg[FLAG_ADDR];
            if (FLAG_WE) begin
                img_reg[FLAG_ADDR] <= FLAG_WDATA;
            end else if (fifo_pop) begin
                img_reg[pop_addr] <= pop_data;
            end
        end
    end

    // ----------------------------------------------------------------
    // Sequencer
    // ----------------------------------------------------------------
    always_ff @(posedge CORE_CLK) begin
        if (RST) begin
            state_reg <= S_IDLE;
            list_reg <= LIST_NONE;
            in_cfg_reg <= '0;
            out_cfg_reg <= '0;
            idx_reg <= '0;
            word_reg <= '0;
            req_reg <= 1'b0;
            we_reg <= 1'b0;
            addr_reg <= '0;
            wdata_reg <= '0;
            tbl_rd_reg <= 1'b0;
            tbl_addr_reg <= '0;
            in_done_reg <= 1'b0;
            out_done_reg <= 1'b0;
            busy_reg <= 1'b0;
            cfg_valid_reg <= 1'b0;
        end else if (CE) begin
            in_done_reg <= 1'b0;
            out_done_reg <= 1'b0;
            case (state_reg)
                S_IDLE: begin
                    idx_reg <= WIN_FIRST;
                    if (RESTART) begin
                        in_cfg_reg <= '0;
                        out_cfg_reg <= '0;
                        cfg_valid_reg <= 1'b0;
                        list_reg <= LIST_NONE;
                        word_reg <= TBL_FIRST;
                        busy_reg <= 1'b1;
                        state_reg <= S_TRD;
                    end else if (PASS_START) begin
                        busy_reg <= 1'b1;
                        state_reg <= S_IN_SCAN;
                    end else if (PASS_END) begin
                        busy_reg <= 1'b1;
                        state_reg <= S_OUT_SCAN;
                    end
                end
                S_TRD: begin
                    tbl_rd_reg <= 1'b1;
                    tbl_addr_reg <= word_reg;
                    state_reg <= S_TWAIT;
                end
                S_TWAIT: begin
                    tbl_rd_reg <= 1'b0;
                    state_reg <= S_TCHK;
                end
                S_TCHK: begin
                    if (hdr_bad) begin
                        in_cfg_reg <= '0;
                        out_cfg_reg <= '0;
                    end else if (!in_header) begin
                        if (TBL_DATA == MARK_INPUT) begin
                            list_reg <= LIST_IN;
                        end else if (TBL_DATA == MARK_OUTPUT) begin
                            list_reg <= LIST_OUT;
                        end else if (is_entry && list_reg == LIST_IN) begin
                            in_cfg_reg[entry_idx] <= 1'b1;
                        end else if (is_entry && list_reg == LIST_OUT) begin
                            out_cfg_reg[entry_idx] <= 1'b1;
                        end
                    end
                    if (parse_stop) begin
                        cfg_valid_reg <= !hdr_bad;
                        busy_reg <= 1'b0;
                        state_reg <= S_IDLE;
                    end else begin
                        word_reg <= word_reg + 1'b1;
                        state_reg <= S_TRD;
                    end
                end
                S_IN_SCAN: begin
                    if (in_cfg_reg[idx_reg]) begin
                        if (fifo_in_ready) begin
                            req_reg <= 1'b1;
                            we_reg <= 1'b0;
                            addr_reg <= idx_reg;
                            state_reg <= S_IN_WAIT;
                        end
                    end else if (idx_last) begin
                        state_reg <= S_IN_DRAIN;
                    end else begin
                        idx_reg <= idx_reg + 1'b1;
                    end
                end
                S_IN_WAIT: begin
                    if (WIN.ack) begin
                        req_reg <= 1'b0;
                        idx_reg <= idx_reg + 1'b1;
                        state_reg <= idx_last ? S_IN_DRAIN : S_IN_SCAN;
                    end
                end
                S_IN_DRAIN: begin
                    if (!fifo_out_valid) begin
                        in_done_reg <= 1'b1;
                        busy_reg <= 1'b0;
                        state_reg <= S_IDLE;
                    end
                end
                S_OUT_SCAN: begin
                    if (out_cfg_reg[idx_reg]) begin
                        req_reg <= 1'b1;
                        we_reg <= 1'b1;
                        addr_reg <= idx_reg;
                        wdata_reg <= img_reg[idx_reg];
                        state_reg <= S_OUT_WAIT;
                    end else if (idx_last) begin
                        out_done_reg <= 1'b1;
                        busy_reg <= 1'b0;
                        state_reg <= S_IDLE;
                    end else begin
                        idx_reg <= idx_reg + 1'b1;
                    end
                end
                S_OUT_WAIT: begin
                    if (WIN.ack) begin
                        req_reg <= 1'b0;
                        we_reg <= 1'b0;
                        idx_reg <= idx_reg + 1'b1;
                        if (idx_last) begin
                            out_done_reg <= 1'b1;
                            busy_reg <= 1'b0;
                            state_reg <= S_IDLE;
                        end else begin
                            state_reg <= S_OUT_SCAN;
                        end
                    end
                end
                default: begin
                    state_reg <= S_IDLE;
                end
            endcase
        end
    end

    // ----------------------------------------------------------------
    // Outputs
    // ----------------------------------------------------------------
    assign WIN.req = req_reg;
    assign WIN.we = we_reg;
    assign WIN.addr = addr_reg;
    assign WIN.wdata = wdata_reg;
    assign TBL_RD = tbl_rd_reg;
    assign TBL_ADDR = tbl_addr_reg;
    assign IN_DONE = in_done_reg;
    assign OUT_DONE = out_done_reg;
    assign BUSY = busy_reg;
    assign CFG_VALID = cfg_valid_reg;
    assign FLAG_RDATA = flag_rdata_reg;
endmodule // flag_xfer_engine
`default_nettype wire

//--- test/comm_flag_transfer_engine_test.sv
`default_nettype none
module comm_flag_transfer_engine_test
    import flag_xfer_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    logic core_clk, rst, ce, restart, pass_start, pass_end, in_done, out_done, busy, cfg_valid;
    logic tbl_rd, tbl_hold, flag_we, peer_we;
    logic [TBL_AW-1:0] tbl_addr;
    logic [TBL_W-1:0] tbl_data;
    logic [TBL_W-1:0] tbl [0:1023];
    logic [WIN_AW-1:0] flag_addr, peer_addr;
    logic [BYTE_W-1:0] flag_wdata, flag_rdata, peer_wdata, peer_rdata;
    logic [BLK_COUNT-1:0] blk_en;
    int n_fail, check_count, n_rd, n_wr;

    flag_win_if i_flag_win_if();

    flag_xfer_engine i_flag_xfer_engine (.CORE_CLK(core_clk), .RST(rst), .CE(ce), .RESTART(restart),
        .PASS_START(pass_start), .PASS_END(pass_end), .IN_DONE(in_done), .OUT_DONE(out_done), .BUSY(busy),
        .CFG_VALID(cfg_valid), .TBL_RD(tbl_rd), .TBL_ADDR(tbl_addr), .TBL_DATA(tbl_data), .FLAG_WE(flag_we),
        .FLAG_ADDR(flag_addr), .FLAG_WDATA(flag_wdata), .FLAG_RDATA(flag_rdata), .WIN(i_flag_win_if));

    flag_window_peer i_flag_window_peer (.CORE_CLK(core_clk), .RST(rst), .CE(ce), .BLK_EN(blk_en),
        .PEER_WE(peer_we), .PEER_ADDR(peer_addr), .PEER_WDATA(peer_wdata), .PEER_RDATA(peer_rdata),
        .WIN(i_flag_win_if));

    flag_xfer_sva i_flag_xfer_sva (.CORE_CLK(core_clk), .RST(rst), .req(i_flag_win_if.req),
        .we(i_flag_win_if.we), .addr(i_flag_win_if.addr), .wdata(i_flag_win_if.wdata),
        .ack(i_flag_win_if.ack), .rdata(i_flag_win_if.rdata));

    initial begin
        core_clk = 1'b0;
        forever #4 core_clk = ~core_clk;
    end

    // ----------------------------------------------------------------
    // Table source and window traffic count
    // ----------------------------------------------------------------
    // Data is inverted once its hold cycle ends, so a late sample never passes
    always @(negedge core_clk) begin
        if (tbl_rd === 1'b1) begin
            tbl_data <= tbl[tbl_addr];
            tbl_hold <= 1'b1;
        end else if (tbl_hold) begin
            tbl_hold <= 1'b0;
        end else begin
            tbl_data <= ~tbl_data;
        end
    end

    always @(negedge core_clk) begin
        if (i_flag_win_if.ack === 1'b1 && i_flag_win_if.we === 1'b1) n_wr++;
        if (i_flag_win_if.ack === 1'b1 && i_flag_win_if.we === 1'b0) n_rd++;
    end

    // ----------------------------------------------------------------
    // Helpers
    // ----------------------------------------------------------------
    function automatic logic [7:0] pv(input logic [7:0] i);
        return i ^ 8'h5A;
    endfunction

    task automatic final_report();
        $display("Checks %0d, mismatches %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    task automatic check(input logic [7:0] seen, input logic [7:0] want);
        check_count++;
        if (seen !== want) begin
            n_fail++;
            $display("BAD at %0t: got %h expected %h", $time, seen, want);
        end
    endtask

    task automatic wait_done(input int sel);
        int n;
        n = 0;
        while ((sel == 1 ? in_done : sel == 2 ? out_done : ~busy) !== 1'b1) begin
            if (n == 5000) begin
                n_fail++;
                $display("BAD at %0t: wait ran out", $time);
                final_report();
            end
            n++;
            @(negedge core_clk);
        end
        check(8'(busy), 8'h00);
    endtask

    task automatic go(input int sel);
        @(negedge core_clk);
        restart = (sel == 0);
        pass_start = (sel == 1);
        pass_end = (sel == 2);
        @(negedge core_clk);
        restart = 1'b0;
        pass_start = 1'b0;
        pass_end = 1'b0;
        wait_done(sel);
    endtask

    task automatic flag_wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge core_clk);
        flag_we = 1'b1;
        flag_addr = a;
        flag_wdata = d;
        @(negedge core_clk);
        flag_we = 1'b0;
    endtask

    task automatic peer_wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge core_clk);
        peer_we = 1'b1;
        peer_addr = a;
        peer_wdata = d;
        @(negedge core_clk);
        peer_we = 1'b0;
    endtask

    task automatic flag_chk(input logic [7:0] a, input logic [7:0] want);
        @(negedge core_clk);
        flag_addr = a;
        @(negedge core_clk);
        check(flag_rdata, want);
    endtask

    task automatic peer_chk(input logic [7:0] a, input logic [7:0] want);
        @(negedge core_clk);
        peer_addr = a;
        @(negedge core_clk);
        check(peer_rdata, want);
    endtask

    // Output list first, unsorted entries, words after the end marker
    task automatic load_table(input logic [15:0] w2, input logic [15:0] o);
        foreach (tbl[i]) tbl[i] = MARK_END;
        tbl[0] = HDR_WORD0;
        tbl[1] = HDR_WORD1;
        tbl[2] = w2;
        tbl[3] = MARK_OUTPUT;
        tbl[4] = o;
        tbl[5] = 16'h0000;
        tbl[6] = MARK_INPUT;
        tbl[7] = 16'h00FF;
        tbl[8] = 16'h0005;
        tbl[9] = 16'h0003;
        for (int k = 0; k < 10; k++) tbl[10+k] = 16'h0028 + 16'(k);
        tbl[21] = MARK_INPUT;
        tbl[22] = 16'h0007;
    endtask

    // ----------------------------------------------------------------
    // Scenarios
    // ----------------------------------------------------------------
    task automatic t_config();
        load_table(HDR_WORD2, 16'h00C8);
        for (int k = 0; k < 256; k++) peer_wr(8'(k), pv(8'(k)));
        n_rd = 0;
        go(0);
        check(8'(cfg_valid), 8'h01);
        check(8'(n_rd), 8'h00);
    endtask

    // Program writes hold the drain, so the inbound buffer fills and fetching stops
    task automatic t_fill();
        logic [7:0] want;
        flag_wr(8'h03, 8'h11);
        n_rd = 0;
        @(negedge core_clk);
        pass_start = 1'b1;
        flag_we = 1'b1;
        flag_addr = 8'h09;
        flag_wdata = 8'h99;
        @(negedge core_clk);
        pass_start = 1'b0;
        repeat (600) @(negedge core_clk);
        check(8'(n_rd < 13), 8'h01);
        check(8'(busy), 8'h01);
        flag_we = 1'b0;
        wait_done(1);
        check(8'(n_rd), 8'h0D);
        for (int k = 0; k < 256; k++) begin
            want = (k == 9) ? 8'h99 : 8'h00;
            if (k == 3 || k == 5 || k == 255 || (k >= 40 && k < 50)) want = pv(8'(k));
            flag_chk(8'(k), want);
        end
    endtask

    task automatic t_outbound();
        flag_wr(8'hC8, 8'hA5);
        flag_wr(8'h00, 8'h3C);
        flag_wr(8'h05, 8'hEE);
        flag_chk(8'hC8, 8'hA5);
        n_wr = 0;
        go(2);
        check(8'(n_wr), 8'h02);
        peer_chk(8'hC8, 8'hA5);
        peer_chk(8'h00, 8'h3C);
        peer_chk(8'h05, pv(8'h05));
        peer_chk(8'h09, pv(8'h09));
    endtask

    task automatic t_restart_only();
        load_table(HDR_WORD2, 16'h0009);
        go(2);
        peer_chk(8'h09, pv(8'h09));
        go(0);
        go(2);
        peer_chk(8'h09, 8'h99);
    endtask

    task automatic t_bad_header();
        load_table(16'h3030, 16'h0009);
        go(0);
        check(8'(cfg_valid), 8'h00);
        peer_wr(8'h05, 8'h66);
        flag_wr(8'h09, 8'h44);
        n_rd = 0;
        n_wr = 0;
        go(1);
        go(2);
        check(8'(n_rd + n_wr), 8'h00);
        flag_chk(8'h05, 8'hEE);
        peer_chk(8'h09, 8'h99);
    endtask

    task automatic t_block_off();
        load_table(HDR_WORD2, 16'h00C8);
        go(0);
        blk_en = 8'hFE;
        flag_wr(8'h00, 8'h11);
        go(2);
        peer_chk(8'h00, 8'h3C);
        go(1);
        flag_chk(8'h03, 8'h00);
        flag_chk(8'hFF, pv(8'hFF));
        blk_en = 8'hFF;
        // Clock enable low must freeze the sequencer, so a start is not seen
        ce = 1'b0;
        pass_start = 1'b1;
        repeat (3) @(negedge core_clk);
        check(8'(busy), 8'h00);
        pass_start = 1'b0;
        ce = 1'b1;
        @(negedge core_clk);
        check(8'(busy), 8'h00);
    endtask

    initial begin
        rst = 1'b1;
        ce = 1'b1;
        restart = 1'b0;
        pass_start = 1'b0;
        pass_end = 1'b0;
        tbl_data = 16'h0000;
        tbl_hold = 1'b0;
        flag_we = 1'b0;
        flag_addr = 8'h00;
        flag_wdata = 8'h00;
        peer_we = 1'b0;
        peer_addr = 8'h00;
        peer_wdata = 8'h00;
        blk_en = 8'hFF;
        n_fail = 0;
        check_count = 0;
        n_rd = 0;
        n_wr = 0;
        repeat (6) @(negedge core_clk);
        rst = 1'b0;
        t_config();
        t_fill();
        t_outbound();
        t_restart_only();
        t_bad_header();
        t_block_off();
        final_report();
    end
endmodule // comm_flag_transfer_engine_test
`default_nettype wire

//--- test/flag_xfer_sva.sv
`default_nettype none
module flag_xfer_sva
    import flag_xfer_pkg::*;
(
    // Clock and reset
    input wire logic CORE_CLK,
    input wire logic RST,
    // Window bus
    input wire logic req,
    input wire logic we,
    input wire logic [WIN_AW-1:0] addr,
    input wire logic [BYTE_W-1:0] wdata,
    input wire logic ack,
    input wire logic [BYTE_W-1:0] rdata
);
    default clocking cb @(posedge CORE_CLK);
    endclocking
    default disable iff (RST);

    // ----------------------------------------------------------------
    // Window handshake
    // ----------------------------------------------------------------
    take_ack_a: assert property (req && !ack |=> ack)
        else $error("window access not answered one cycle after take");
    ack_pulse_a: assert property (ack |=> !ack)
        else $error("window answer longer than one cycle");
    ack_req_a: assert property (ack |-> req)
        else $error("window answer without a request");
    req_drop_a: assert property (ack |=> !req)
        else $error("request not dropped after answer");
    req_hold_a: assert property (req && !ack |=> req && $stable(addr) && $stable(we) && $stable(wdata))
        else $error("request changed before its answer");
    req_width_a: assert property (req ##1 req |=> !req)
        else $error("request held past two cycles");
    rise_clean_a: assert property ($rose(req) |-> !ack)
        else $error("new request while an answer is still up");
    // A one-edge reset in mid-run clears the read data to zero
    rdata_hold_a: assert property (!ack && !$past(RST) |-> $stable(rdata))
        else $error("read data moved outside an answer cycle");
endmodule // flag_xfer_sva
`default_nettype wire
